// file: hw/rdb_pkg.sv
// Package: register map, reset values and carrier types of the receive DMA base registers
// Function
// RULE1: Low descriptor base half waits in holding
// RULE2: High write loads full descriptor base
// RULE3: Descriptor address is offset plus base[31:4]
// RULE4: Host zeroes descriptor base low four bits
// RULE5: Low queue base half waits in holding
// RULE6: High write loads full queue base
// RULE7: One queue base serves all queues
// RULE8: Host zeroes queue base low two bits
// RULE9: Large start index shifted two, plus base
// RULE10: Upper sixteen written bits are ignored
package rdb_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [11:0] RDB_OFF_DTB_LO   = 12'h288;
  localparam logic [11:0] RDB_OFF_DTB_HI   = 12'h28c;
  localparam logic [11:0] RDB_OFF_QB_LO    = 12'h290;
  localparam logic [11:0] RDB_OFF_QB_HI    = 12'h294;
  localparam logic [11:0] RDB_OFF_LFQ_S    = 12'h298;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int          RDB_HALF_W       = 16;
  localparam int          RDB_DESC_OFF_W   = 14;
  localparam int          RDB_DESC_SHIFT   = 4;
  localparam int          RDB_QIDX_SHIFT   = 2;
  localparam logic [15:0] RDB_HALF_RST     = 16'h0000;
  localparam logic [1:0]  RDB_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RDB_RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic [31:0] desc_base;
    logic [31:0] queue_base;
    logic [15:0] lfq_start;
  } rdb_bases_t;

endpackage

// file: hw/rdb_half_pair.sv
// Module: two-half address register with a holding stage for the low word
`timescale 1ns/100ps
module rdb_half_pair
  import rdb_pkg::*;
(
  input  wire logic        aclk,      // Clock
  input  wire logic        aresetn,   // Sync reset, low
  input  wire logic        wr_lo,     // Low half write
  input  wire logic        wr_hi,     // High half write
  input  wire logic [15:0] wdata,     // Written half
  output logic      [15:0] hold_q,    // Held low half
  output logic      [31:0] active_q   // Active address
);

  logic [15:0] hold_r;
  logic [15:0] hold_nxt;
  logic [31:0] active_r;
  logic [31:0] active_nxt;

  always_comb
  begin
    hold_nxt   = hold_r;
    active_nxt = active_r;
    if (wr_lo)
      hold_nxt = wdata;                          // RULE1 RULE5
    if (wr_hi)
      active_nxt = {wdata, hold_r};              // RULE2 RULE6
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hold_r   <= RDB_HALF_RST;
      active_r <= {RDB_HALF_RST, RDB_HALF_RST};
    end
    else
    begin
      hold_r   <= hold_nxt;
      active_r <= active_nxt;
    end
  end

  assign hold_q   = hold_r;
  assign active_q = active_r;

endmodule

// file: hw/rdb_addr_calc.sv
// Module: registered physical address formation for descriptors and queue elements
`timescale 1ns/100ps
module rdb_addr_calc
  import rdb_pkg::*;
(
  input  wire logic             aclk,        // Clock
  input  wire logic             aresetn,     // Sync reset, low
  input  wire rdb_bases_t       bases,       // Active bases
  input  wire logic [13:0]      desc_off,    // Descriptor offset
  input  wire logic [15:0]      q_index,     // Queue index
  output logic      [31:0]      desc_addr,   // Descriptor address
  output logic      [31:0]      q_addr,      // Queue element address
  output logic      [31:0]      lfq_addr     // Large free start addr
);

  logic [31:0] desc_r;
  logic [31:0] desc_nxt;
  logic [31:0] q_r;
  logic [31:0] q_nxt;
  logic [31:0] lfq_r;
  logic [31:0] lfq_nxt;
  logic [27:0] dsum;

  always_comb
  begin
    // Base bits [31:4] plus offset; low nibble stays zero
    dsum     = 28'(bases.desc_base[31:RDB_DESC_SHIFT] + {14'h0000, desc_off});  // RULE3
    desc_nxt = {dsum, 4'h0};
    q_nxt    = 32'(bases.queue_base + {14'h0000, q_index, 2'h0});               // RULE7
    lfq_nxt  = 32'(bases.queue_base + {14'h0000, bases.lfq_start, 2'h0});       // RULE9
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      desc_r <= 32'h0000_0000;
      q_r    <= 32'h0000_0000;
      lfq_r  <= 32'h0000_0000;
    end
    else
    begin
      desc_r <= desc_nxt;
      q_r    <= q_nxt;
      lfq_r  <= lfq_nxt;
    end
  end

  assign desc_addr = desc_r;
  assign q_addr    = q_r;
  assign lfq_addr  = lfq_r;

endmodule

// file: hw/rdb_top.sv
// Module: AXI4-Lite slave holding the receive DMA base address registers
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/100ps
module rdb_top
  import rdb_pkg::*;
(
  input  wire logic        aclk,         // Clock, 10 MHz
  input  wire logic        aresetn,      // Sync reset, low
  input  wire logic [11:0] s_awaddr,     // Write address
  input  wire logic [2:0]  s_awprot,     // Unused
  input  wire logic        s_awvalid,    // Write address valid
  output logic             s_awready,    // Write address ready
  input  wire logic [31:0] s_wdata,      // Write data
  input  wire logic [3:0]  s_wstrb,      // Byte strobes
  input  wire logic        s_wvalid,     // Write data valid
  output logic             s_wready,     // Write data ready
  output logic [1:0]       s_bresp,      // Write response
  output logic             s_bvalid,     // Write response valid
  input  wire logic        s_bready,     // Write response ready
  input  wire logic [11:0] s_araddr,     // Read address
  input  wire logic [2:0]  s_arprot,     // Unused
  input  wire logic        s_arvalid,    // Read address valid
  output logic             s_arready,    // Read address ready
  output logic [31:0]      s_rdata,      // Read data
  output logic [1:0]       s_rresp,      // Read response
  output logic             s_rvalid,     // Read valid
  input  wire logic        s_rready,     // Read ready
  input  wire logic [13:0] desc_off,     // Descriptor offset from DMA
  input  wire logic [15:0] q_index,      // Queue index from DMA
  output logic [31:0]      desc_addr,    // Descriptor physical address
  output logic [31:0]      q_addr,       // Queue element address
  output logic [31:0]      lfq_addr,     // Large free queue start address
  output logic [31:0]      desc_base,    // Active descriptor base
  output logic [31:0]      queue_base    // Active queue base
);

  // ****************************************
  // Write channel
  // ****************************************
  logic        aw_full_r, aw_full_nxt;
  logic        w_full_r,  w_full_nxt;
  logic [11:0] awaddr_r,  awaddr_nxt;
  logic [31:0] wdata_r,   wdata_nxt;
  logic [3:0]  wstrb_r,   wstrb_nxt;
  logic        bvalid_r,  bvalid_nxt;
  logic [1:0]  bresp_r,   bresp_nxt;
  logic        do_wr;
  logic        lo_en;
  logic        wr_dtb_lo, wr_dtb_hi, wr_qb_lo, wr_qb_hi;
  logic [15:0] lfq_r,     lfq_nxt;
  // Ready kept in its own flop so the port sees no gate
  logic        awready_r, awready_nxt;
  logic        wready_r,  wready_nxt;

  assign do_wr = aw_full_r && w_full_r && !bvalid_r;
  // Unused upper lanes do not gate the write; low half needs both low lanes
  assign lo_en = &wstrb_r[1:0];

  always_comb
  begin
    aw_full_nxt = aw_full_r;
    w_full_nxt  = w_full_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    lfq_nxt     = lfq_r;
    wr_dtb_lo   = 1'b0;
    wr_dtb_hi   = 1'b0;
    wr_qb_lo    = 1'b0;
    wr_qb_hi    = 1'b0;
    if (s_awvalid && !aw_full_r)
    begin
      aw_full_nxt = 1'b1;
      awaddr_nxt  = s_awaddr;
    end
    if (s_wvalid && !w_full_r)
    begin
      w_full_nxt = 1'b1;
      wdata_nxt  = s_wdata;
      wstrb_nxt  = s_wstrb;
    end
    if (do_wr)
    begin
      aw_full_nxt = 1'b0;
      w_full_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = RDB_RESP_OKAY;
      unique case ({awaddr_r[11:2], 2'h0})
        RDB_OFF_DTB_LO: wr_dtb_lo = lo_en;
        RDB_OFF_DTB_HI: wr_dtb_hi = lo_en;
        RDB_OFF_QB_LO:  wr_qb_lo  = lo_en;
        RDB_OFF_QB_HI:  wr_qb_hi  = lo_en;
        RDB_OFF_LFQ_S:  lfq_nxt   = lo_en ? wdata_r[15:0] : lfq_r;  // RULE10
        default:        bresp_nxt = RDB_RESP_SLVERR;
      endcase
    end
    if (bvalid_r && s_bready)
      bvalid_nxt = 1'b0;
    awready_nxt = !aw_full_nxt;
    wready_nxt  = !w_full_nxt;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      awaddr_r  <= 12'h000;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RDB_RESP_OKAY;
      lfq_r     <= RDB_HALF_RST;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
    end
    else
    begin
      aw_full_r <= aw_full_nxt;
      w_full_r  <= w_full_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      lfq_r     <= lfq_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
    end
  end

  assign s_awready = awready_r;
  assign s_wready  = wready_r;
  assign s_bvalid  = bvalid_r;
  assign s_bresp   = bresp_r;

  // ****************************************
  // Address pairs
  // ****************************************
  logic [15:0] dtb_hold, qb_hold;
  logic [31:0] dtb_act, qb_act;
  rdb_bases_t  bases;

  // Only the low 16 data bits reach the pairs, upper bits drop here
  rdb_half_pair u_dtb (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .wr_lo    (wr_dtb_lo),
    .wr_hi    (wr_dtb_hi),
    .wdata    (wdata_r[15:0]),      // RULE10
    .hold_q   (dtb_hold),
    .active_q (dtb_act)
  );

  rdb_half_pair u_qb (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .wr_lo    (wr_qb_lo),
    .wr_hi    (wr_qb_hi),
    .wdata    (wdata_r[15:0]),      // RULE10
    .hold_q   (qb_hold),
    .active_q (qb_act)
  );

  assign bases.desc_base  = dtb_act;
  assign bases.queue_base = qb_act;
  assign bases.lfq_start  = lfq_r;
  assign desc_base        = dtb_act;
  assign queue_base       = qb_act;

  rdb_addr_calc u_calc (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .bases     (bases),
    .desc_off  (desc_off),
    .q_index   (q_index),
    .desc_addr (desc_addr),
    .q_addr    (q_addr),
    .lfq_addr  (lfq_addr)
  );

  // ****************************************
  // Read channel
  // ****************************************
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r,  rdata_nxt;
  logic [1:0]  rresp_r,  rresp_nxt;
  logic        arready_r, arready_nxt;

  always_comb
  begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (s_arvalid && !rvalid_r)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RDB_RESP_OKAY;
      // Low half reads back the held word, high half the active one
      unique case ({s_araddr[11:2], 2'h0})
        RDB_OFF_DTB_LO: rdata_nxt = {16'h0000, dtb_hold};
        RDB_OFF_DTB_HI: rdata_nxt = {16'h0000, dtb_act[31:16]};
        RDB_OFF_QB_LO:  rdata_nxt = {16'h0000, qb_hold};
        RDB_OFF_QB_HI:  rdata_nxt = {16'h0000, qb_act[31:16]};
        RDB_OFF_LFQ_S:  rdata_nxt = {16'h0000, lfq_r};
        default:
        begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = RDB_RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_r && s_rready)
      rvalid_nxt = 1'b0;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RDB_RESP_OKAY;
      arready_r <= 1'b1;
    end
    else
    begin
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rresp_nxt;
      arready_r <= arready_nxt;
    end
  end

  assign s_arready = arready_r;
  assign s_rvalid  = rvalid_r;
  assign s_rdata   = rdata_r;
  assign s_rresp   = rresp_r;

endmodule

// file: sim/rdb_assertions.sv
// Checker: handshakes and address forming at the block ports
`timescale 1ns/100ps
module rdb_assertions
(
  input wire logic        aclk,       // Clock
  input wire logic        aresetn,    // Reset
  input wire logic        s_bvalid,   // B valid
  input wire logic        s_bready,   // B ready
  input wire logic        s_arvalid,  // AR valid
  input wire logic        s_arready,  // AR ready
  input wire logic        s_rvalid,   // R valid
  input wire logic        s_rready,   // R ready
  input wire logic [13:0] desc_off,   // Offset
  input wire logic [15:0] q_index,    // Index
  input wire logic [31:0] desc_addr,  // Desc addr
  input wire logic [31:0] q_addr,     // Queue addr
  input wire logic [31:0] lfq_addr,   // Start addr
  input wire logic [31:0] desc_base,  // Desc base
  input wire logic [31:0] queue_base  // Queue base
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ******************
  // Properties
  // ******************
  // Outputs lag one edge; the first edge after reset still holds reset values
  property p_da; $past(aresetn) |-> desc_addr == {$past(desc_base[31:4]) + 28'($past(desc_off)), 4'h0}; endproperty
  a_da: assert property (p_da) else $error("desc addr");
  property p_qa; $past(aresetn) |-> q_addr == $past(queue_base) + {14'h0, $past(q_index), 2'h0}; endproperty
  a_qa: assert property (p_qa) else $error("queue addr");
  property p_la; $past(aresetn) |-> ((lfq_addr - $past(queue_base)) & 32'hfffc_0003) == 32'h0; endproperty
  a_la: assert property (p_la) else $error("start addr");
  property p_dc; $past(aresetn) && $changed(desc_base) |-> $rose(s_bvalid); endproperty
  a_dc: assert property (p_dc) else $error("desc base");
  property p_qc; $past(aresetn) && $changed(queue_base) |-> $rose(s_bvalid); endproperty
  a_qc: assert property (p_qc) else $error("queue base");
  property p_bh; s_bvalid && !s_bready |=> s_bvalid; endproperty
  a_bh: assert property (p_bh) else $error("bvalid drop");
  property p_rl; s_arvalid && s_arready |=> s_rvalid; endproperty
  a_rl: assert property (p_rl) else $error("read late");
  property p_rh; s_rvalid && !s_rready |=> s_rvalid; endproperty
  a_rh: assert property (p_rh) else $error("rvalid drop");
endmodule
bind rdb_top rdb_assertions u_chk (
  .aclk       (aclk),
  .aresetn    (aresetn),
  .s_bvalid   (s_bvalid),
  .s_bready   (s_bready),
  .s_arvalid  (s_arvalid),
  .s_arready  (s_arready),
  .s_rvalid   (s_rvalid),
  .s_rready   (s_rready),
  .desc_off   (desc_off),
  .q_index    (q_index),
  .desc_addr  (desc_addr),
  .q_addr     (q_addr),
  .lfq_addr   (lfq_addr),
  .desc_base  (desc_base),
  .queue_base (queue_base)
);

// file: sim/rdb_dma.sv
// DMA-side model: offers descriptor offset and queue index
`timescale 1ns/100ps
module rdb_dma
(
  input  wire logic        aclk,      // Clock
  output logic      [13:0] desc_off,  // Offset
  output logic      [15:0] q_index    // Index
);
  initial {desc_off, q_index} = '0;
  task automatic point(input logic [13:0] o, input logic [15:0] i);
    @(posedge aclk);
    desc_off <= o;
    q_index <= i;
  endtask
endmodule

// file: sim/rdb_top_tb.sv
// Testbench: register access and address forming of the base registers
`timescale 1ns/100ps
module rdb_top_tb
  import rdb_pkg::*;
;
  localparam logic [31:0] DB = 32'h8765_1230;
  localparam logic [31:0] QB = 32'h0012_fffc;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, desc_addr, q_addr, lfq_addr, desc_base, queue_base, q;
  logic [13:0] desc_off;
  logic [15:0] q_index;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  int          n_fail = 0;
  int          n_checks = 0;

  rdb_top dut (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .s_awaddr   (s_awaddr),
    .s_awprot   (3'h0),
    .s_awvalid  (s_awvalid),
    .s_awready  (s_awready),
    .s_wdata    (s_wdata),
    .s_wstrb    (s_wstrb),
    .s_wvalid   (s_wvalid),
    .s_wready   (s_wready),
    .s_bresp    (s_bresp),
    .s_bvalid   (s_bvalid),
    .s_bready   (s_bready),
    .s_araddr   (s_araddr),
    .s_arprot   (3'h0),
    .s_arvalid  (s_arvalid),
    .s_arready  (s_arready),
    .s_rdata    (s_rdata),
    .s_rresp    (s_rresp),
    .s_rvalid   (s_rvalid),
    .s_rready   (s_rready),
    .desc_off   (desc_off),
    .q_index    (q_index),
    .desc_addr  (desc_addr),
    .q_addr     (q_addr),
    .lfq_addr   (lfq_addr),
    .desc_base  (desc_base),
    .queue_base (queue_base)
  );
  rdb_dma dma (.aclk(aclk), .desc_off(desc_off), .q_index(q_index));

  initial forever #50 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Extra leading edge keeps ready drops and raises in separate steps
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    {s_awaddr, s_araddr, s_wdata} <= {a, a, d};
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} <= {w, w, w, !w, !w};
    do
    begin
      @(posedge aclk);
      n++;
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      if (s_arready) s_arvalid <= 1'b0;
    end
    while (!(w ? s_bvalid : s_rvalid) && n < 50);
    {s_bready, s_rready} <= 2'b00;
    q = s_rdata;
    if (!(w ? s_bvalid : s_rvalid))
    begin
      n_fail++;
      final_report();
    end
    else
      chk({30'h0, w ? s_bresp : s_rresp}, {30'h0, er});
  endtask

  // ******************
  // Scenarios
  // ******************
  task automatic t_pair(input logic qs, input logic [11:0] lo, input logic [31:0] dl, input logic [31:0] dh);
    acc(1'b0, lo, 32'h0, RDB_RESP_OKAY);
    chk(q, 32'h0);
    acc(1'b1, lo, 32'h0000_7770, RDB_RESP_OKAY);
    acc(1'b1, lo, dl, RDB_RESP_OKAY);
    chk(qs ? queue_base : desc_base, 32'h0);
    acc(1'b0, lo, 32'h0, RDB_RESP_OKAY);
    chk(q, {16'h0, dl[15:0]});
    acc(1'b1, lo + 12'h4, dh, RDB_RESP_OKAY);
    chk(qs ? queue_base : desc_base, {dh[15:0], dl[15:0]});
  endtask

  task automatic t_addr;
    acc(1'b1, RDB_OFF_LFQ_S, 32'hdead_8001, RDB_RESP_OKAY);
    dma.point(14'h3fff, 16'hffff);
    repeat (2) @(posedge aclk);
    chk(desc_addr, {DB[31:4] + 28'h3fff, 4'h0});
    chk(q_addr, QB + 32'h3fffc);
    chk(lfq_addr, QB + 32'h20004);
    acc(1'b0, RDB_OFF_LFQ_S, 32'h0, RDB_RESP_OKAY);
    chk(q, 32'h8001);
  endtask

  task automatic t_bad;
    acc(1'b1, 12'h2a0, 32'hffff_ffff, RDB_RESP_SLVERR);
    acc(1'b0, 12'h2a0, 32'h0, RDB_RESP_SLVERR);
    chk(q, 32'h0);
    chk(desc_base, DB);
    chk(queue_base, QB);
    acc(1'b1, RDB_OFF_DTB_HI, 32'h0000_4321, RDB_RESP_OKAY);
    chk(desc_base, {16'h4321, DB[15:0]});
    // Upper lanes only: low half lanes absent, write has no effect
    s_wstrb <= 4'hc;
    acc(1'b1, RDB_OFF_DTB_HI, 32'h0000_9999, RDB_RESP_OKAY);
    s_wstrb <= 4'hf;
    chk(desc_base, {16'h4321, DB[15:0]});
  endtask

  task automatic t_rst;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(desc_base, 32'h0);
    chk(queue_base, 32'h0);
    acc(1'b0, RDB_OFF_LFQ_S, 32'h0, RDB_RESP_OKAY);
    chk(q, 32'h0);
    chk(desc_addr, 32'h0003_fff0);
    chk(q_addr, 32'h0003_fffc);
    chk(lfq_addr, 32'h0);
  endtask

  initial
  begin
    {s_awaddr, s_araddr, s_wdata, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    s_wstrb = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_pair(1'b0, RDB_OFF_DTB_LO, {16'habcd, DB[15:0]}, {16'hffff, DB[31:16]});
    t_pair(1'b1, RDB_OFF_QB_LO, {16'h5555, QB[15:0]}, {16'h1234, QB[31:16]});
    t_addr();
    t_bad();
    t_rst();
    final_report();
  end
endmodule
